// ===== verilog/ecs_map.vh
`ifndef ECS_MAP_VH
`define ECS_MAP_VH
// ****************************************
// Register byte offsets on APB
// ****************************************
`define ECS_OFF_CMD 12'h000
`define ECS_OFF_CONTROL_REGISTER_A 12'h004
`define ECS_OFF_STATUS 12'h008
`define ECS_OFF_ADDR 12'h00C
`define ECS_OFF_DATA 12'h010
`define ECS_OFF_DBG 12'h014
// ****************************************
// Fields
// ****************************************
`define ECS_EXEC_BIT 0
`define ECS_BUSY_BIT 0
`define ECS_RDBLK_BIT 1
`define ECS_MEMEN_BIT 2
// ****************************************
// Operation codes
// ****************************************
`define ECS_OP_NONE 7'h00
`define ECS_OP_READ 7'h06
`define ECS_OP_ERASE_ALL 7'h30
`define ECS_OP_ERASE_PAGE 7'h32
`define ECS_OP_LOAD_BUF 7'h33
`define ECS_OP_WRITE_PAGE 7'h34
`define ECS_OP_ERASE_WRITE 7'h35
`define ECS_OP_ERASE_BUF 7'h36
// ****************************************
// Debug enable keys, erased byte value and data memory base
// ****************************************
`define ECS_DBG_RESET_KEY 8'h59
`define ECS_DBG_MEM_KEY 8'hA5
`define ECS_ERASED_BYTE 8'hFF
`define ECS_DATAMEM_BASE 25'h1000000
`endif

// ===== verilog/ecs_sequencer.v
// Contract
// - With load code selected and the sequencer idle, each data byte write stores into buffer at low address.
// - Erase-buffer code plus execute bit clears the whole page buffer.
// - Busy flag stays set from start to end of long operations.
// - Page erase erases only tagged locations of addressed page.
// - Page write programs only tagged locations of addressed page.
// - Erase-and-write erases then programs the page as one uninterruptible operation.
// - Full erase clears tagged locations in every page, no address needed.
// - Read operation with execute fetches one byte into the data register.
// - Once enabled flag is set, memory interface is active to debug side.
// - Debug addresses are byte addresses; data memory sits at the stated base.
// - Buffer location uses only low address bits; full address still supplied.
// - Reads of memory are blocked while a page erase or write is busy.
// - Codes decode to erase page, write page, erase-and-write page.
// - Codes decode to load buffer, erase buffer, erase whole memory.
// - Action operations start when software sets the execute bit.
`timescale 1ns/1ps
`include "ecs_map.vh"
module ecs_sequencer #(
  parameter PAGE_BITS = 5,
  parameter NPAGE_BITS = 3,
  parameter STEP_CYCLES = 4
) (
  pclk,
  presetn,
  psel,
  penable,
  pwrite,
  paddr,
  pwdata,
  prdata,
  pready,
  pslverr,
  busy,
  mem_access_enabled
);

  // ****************************************
  // Derived sizes
  // ****************************************
  localparam PSZ = 1 << PAGE_BITS;
  localparam AW = PAGE_BITS + NPAGE_BITS;
  localparam MSZ = 1 << AW;

  // ****************************************
  // Ports
  // ****************************************
  input wire pclk;
  input wire presetn;
  input wire psel;
  input wire penable;
  input wire pwrite;
  input wire [11:0] paddr;
  input wire [31:0] pwdata;
  output reg [31:0] prdata;
  output wire pready;
  output reg pslverr;
  output reg busy;
  output reg mem_access_enabled;

  // ****************************************
  // States
  // ****************************************
  localparam [4:0] S_IDLE = 5'b00001;
  localparam [4:0] S_ERASE = 5'b00010;
  localparam [4:0] S_PROG = 5'b00100;
  localparam [4:0] S_CLRBUF = 5'b01000;
  localparam [4:0] S_WAIT = 5'b10000;

  // ****************************************
  // Storage
  // ****************************************
  reg [6:0] cmd_ff;
  reg [24:0] addr_ff;
  reg [7:0] data_ff;
  reg [7:0] buf_ff [0:PSZ-1];
  reg [PSZ-1:0] tag_ff;
  reg [7:0] mem_ff [0:MSZ-1];
  reg [4:0] state_ff;
  reg [6:0] op_ff;
  reg [NPAGE_BITS:0] page_ff;
  reg [7:0] cnt_ff;
  reg dbg_rst_ok_ff;
  reg ack_ff;
  integer i;

  // ****************************************
  // Helpers
  // ****************************************
  // Only the page operations and full erase hold the array, so only they block reads
  function is_page_op;
    input [6:0] op;
    begin
      case (op)
        `ECS_OP_ERASE_PAGE: is_page_op = 1'b1;
        `ECS_OP_WRITE_PAGE: is_page_op = 1'b1;
        `ECS_OP_ERASE_WRITE: is_page_op = 1'b1;
        `ECS_OP_ERASE_ALL: is_page_op = 1'b1;
        default: is_page_op = 1'b0;
      endcase
    end
  endfunction

  // Buffer slot from the low address bits only
  function [PAGE_BITS-1:0] buf_slot;
    input [24:0] a;
    begin
      buf_slot = a[PAGE_BITS-1:0];
    end
  endfunction

  // Page number inside the array; address bits above it are ignored
  function [NPAGE_BITS-1:0] page_of;
    input [24:0] a;
    begin
      page_of = a[AW-1:PAGE_BITS];
    end
  endfunction

  // ****************************************
  // Bus decode
  // ****************************************
  wire wr = psel && penable && pwrite && !ack_ff;
  wire rd = psel && penable && !pwrite && !ack_ff;
  wire [11:0] off = paddr;
  wire known = (off == `ECS_OFF_CMD) || (off == `ECS_OFF_CONTROL_REGISTER_A) || (off == `ECS_OFF_STATUS) ||
               (off == `ECS_OFF_ADDR) || (off == `ECS_OFF_DATA) || (off == `ECS_OFF_DBG);
  wire idle = state_ff == S_IDLE;
  wire exec = wr && off == `ECS_OFF_CONTROL_REGISTER_A && pwdata[`ECS_EXEC_BIT] && idle;
  wire rd_block = busy && is_page_op(op_ff);

  // Index into flat storage; page bits above the EEPROM size are dropped
  function [AW-1:0] mem_idx;
    input [NPAGE_BITS-1:0] pg;
    input [PAGE_BITS-1:0] by;
    begin
      mem_idx = {pg, by};
    end
  endfunction

  // Single-cycle wait state keeps the answer registered
  assign pready = ack_ff;

  // ****************************************
  // APB slave and sequencer
  // ****************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // ****************************************
      // Reset values
      // ****************************************
      cmd_ff <= `ECS_OP_NONE;
      addr_ff <= 25'h0000000;
      data_ff <= 8'h00;
      tag_ff <= {PSZ{1'b0}};
      state_ff <= S_IDLE;
      op_ff <= `ECS_OP_NONE;
      page_ff <= {(NPAGE_BITS+1){1'b0}};
      cnt_ff <= 8'h00;
      busy <= 1'b0;
      mem_access_enabled <= 1'b0;
      dbg_rst_ok_ff <= 1'b0;
      ack_ff <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
      for (i = 0; i < PSZ; i = i + 1) begin
        buf_ff[i] <= 8'h00;
      end
      for (i = 0; i < MSZ; i = i + 1) begin
        mem_ff[i] <= `ECS_ERASED_BYTE;
      end
    end else begin
      ack_ff <= psel && penable && !ack_ff;
      pslverr <= psel && penable && !ack_ff && !known;

      // ****************************************
      // Read data
      // ****************************************
      if (rd) begin
        case (off)
          `ECS_OFF_CMD: prdata <= {25'h0000000, cmd_ff};
          `ECS_OFF_STATUS: prdata <= {29'h00000000, mem_access_enabled, rd_block, busy};
          `ECS_OFF_ADDR: prdata <= {7'h00, addr_ff};
          `ECS_OFF_DATA: prdata <= {24'h000000, data_ff};
          default: prdata <= 32'h00000000;
        endcase
      end

      // ****************************************
      // Register writes
      // ****************************************
      if (wr) begin
        case (off)
          `ECS_OFF_CMD: cmd_ff <= pwdata[6:0];
          `ECS_OFF_ADDR: addr_ff <= pwdata[24:0];
          `ECS_OFF_DATA: begin
            data_ff <= pwdata[7:0];
            if (cmd_ff == `ECS_OP_LOAD_BUF && idle) begin
              buf_ff[buf_slot(addr_ff)] <= pwdata[7:0];
              tag_ff[buf_slot(addr_ff)] <= 1'b1;
            end
          end
          `ECS_OFF_DBG: begin
            // Enable needs the reset key first, then the memory key
            if (pwdata[7:0] == `ECS_DBG_RESET_KEY) begin
              dbg_rst_ok_ff <= 1'b1;
              mem_access_enabled <= 1'b0;
            end else if (dbg_rst_ok_ff && pwdata[7:0] == `ECS_DBG_MEM_KEY) begin
              mem_access_enabled <= 1'b1;
            end else begin
              dbg_rst_ok_ff <= 1'b0;
            end
          end
          default: ;
        endcase
      end

      // ****************************************
      // Execute
      // ****************************************
      if (exec) begin
        op_ff <= cmd_ff;
        page_ff <= {(NPAGE_BITS+1){1'b0}};
        cnt_ff <= 8'h00;
        case (cmd_ff)
          `ECS_OP_READ: begin
            if (!rd_block) begin
              data_ff <= mem_ff[mem_idx(page_of(addr_ff), buf_slot(addr_ff))];
            end
          end
          `ECS_OP_ERASE_BUF: begin
            busy <= 1'b1;
            state_ff <= S_CLRBUF;
          end
          `ECS_OP_ERASE_PAGE, `ECS_OP_ERASE_WRITE, `ECS_OP_ERASE_ALL: begin
            busy <= 1'b1;
            state_ff <= S_ERASE;
          end
          `ECS_OP_WRITE_PAGE: begin
            busy <= 1'b1;
            state_ff <= S_PROG;
          end
          default: ;
        endcase
      end

      // ****************************************
      // Operation steps
      // ****************************************
      case (state_ff)
        S_IDLE: ;
        S_CLRBUF: begin
          for (i = 0; i < PSZ; i = i + 1) begin
            buf_ff[i] <= 8'h00;
          end
          tag_ff <= {PSZ{1'b0}};
          state_ff <= S_WAIT;
        end
        S_ERASE: begin
          for (i = 0; i < PSZ; i = i + 1) begin
            if (tag_ff[i]) begin
              if (op_ff == `ECS_OP_ERASE_ALL) begin
                mem_ff[mem_idx(page_ff[NPAGE_BITS-1:0], i[PAGE_BITS-1:0])] <= `ECS_ERASED_BYTE;
              end else begin
                mem_ff[mem_idx(page_of(addr_ff), i[PAGE_BITS-1:0])] <= `ECS_ERASED_BYTE;
              end
            end
          end
          if (op_ff == `ECS_OP_ERASE_ALL) begin
            page_ff <= page_ff + {{NPAGE_BITS{1'b0}}, 1'b1};
            if (page_ff[NPAGE_BITS-1:0] == {NPAGE_BITS{1'b1}}) begin
              state_ff <= S_WAIT;
            end
          end else if (op_ff == `ECS_OP_ERASE_WRITE) begin
            state_ff <= S_PROG;
          end else begin
            state_ff <= S_WAIT;
          end
        end
        S_PROG: begin
          for (i = 0; i < PSZ; i = i + 1) begin
            if (tag_ff[i]) begin
              mem_ff[mem_idx(page_of(addr_ff), i[PAGE_BITS-1:0])] <= buf_ff[i];
            end
          end
          state_ff <= S_WAIT;
        end
        S_WAIT: begin
          // Models the cell programming time; busy drops only when it ends
          if (cnt_ff == STEP_CYCLES[7:0]) begin
            busy <= 1'b0;
            state_ff <= S_IDLE;
          end else begin
            cnt_ff <= cnt_ff + 8'h01;
          end
        end
        default: state_ff <= S_IDLE;
      endcase
    end
  end
endmodule

// ===== test/ecs_apb_host.sv
`timescale 1ns/1ps
// ****
// APB master in place of software
// ****
module ecs_apb_host (
  input wire pclk,
  output reg psel,
  output reg penable,
  output reg pwrite,
  output reg [11:0] paddr,
  output reg [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
  end
  // Caller orders code, address, data; no unlock step is modelled
  task xfer(input w, input [11:0] a, input [31:0] d, output [31:0] r, output e);
    begin
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Released data must not look valid
      pwdata <= ~d;
    end
  endtask
endmodule

// ===== test/ecs_checker_assertions.sv
`timescale 1ns/1ps
module ecs_checker #(
  parameter STEP_CYCLES = 4
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire pslverr,
  input wire busy,
  input wire mem_access_enabled
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire tk = psel & penable & ~pready & pwrite;
  reg [2:0] ex_ff;
  reg [1:0] key_ff;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ex_ff <= 3'h0;
      key_ff <= 2'h0;
    end else begin
      ex_ff <= {ex_ff[1:0], tk & (paddr == 12'h004) & pwdata[0]};
      key_ff <= {key_ff[0], tk & (paddr == 12'h014) & (pwdata[7:0] == 8'hA5)};
    end
  end
  sequence s_setup; psel && !penable; endsequence
  sequence s_wait; psel && penable && !pready; endsequence
  chk_one_wait: assert property (s_setup ##1 s_wait |=> pready)
    else $error("pready late");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready too long");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr alone");
  chk_unmapped_err: assert property (psel && penable && !pready && paddr > 12'h014 |=> pslverr)
    else $error("no pslverr");
  chk_busy_cause: assert property ($rose(busy) |-> |ex_ff)
    else $error("busy without execute");
  chk_busy_hold: assert property ($rose(busy) |-> busy [*3])
    else $error("busy dropped early");
  chk_busy_end: assert property ($rose(busy) |-> ##[1:60] !busy)
    else $error("busy stuck");
  chk_key_enable: assert property ($rose(mem_access_enabled) |-> |key_ff)
    else $error("enabled without key");
  chk_key_clear: assert property (tk && paddr == 12'h014 && pwdata[7:0] == 8'h59 |=> !mem_access_enabled)
    else $error("enable not cleared");
endmodule
bind ecs_sequencer ecs_checker #(.STEP_CYCLES(STEP_CYCLES)) i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .busy(busy), .mem_access_enabled(mem_access_enabled));

// ===== test/eeprom_command_sequencer_bench.sv
`timescale 1ns/1ps
`include "ecs_map.vh"
module eeprom_command_sequencer_bench;
  reg pclk;
  reg presetn;
  wire psel, penable, pwrite, pready, pslverr, busy, mem_access_enabled;
  wire [11:0] paddr;
  wire [31:0] pwdata, prdata;
  reg [31:0] r;
  reg e;
  integer bad_count, check_count, i;
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  ecs_sequencer i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .busy(busy),
    .mem_access_enabled(mem_access_enabled));
  ecs_apb_host i_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  task cmp(input [31:0] g, input [31:0] x);
    begin
      check_count = check_count + 1;
      if (g !== x) begin
        bad_count = bad_count + 1;
        $display("mismatch at %0t: got %h expected %h", $time, g, x);
      end
    end
  endtask
  task wr(input [11:0] a, input [31:0] d);
    i_host.xfer(1'b1, a, d, r, e);
  endtask
  task rd(input [11:0] a, input [31:0] x);
    begin
      i_host.xfer(1'b0, a, 32'h0, r, e);
      cmp(r, x);
    end
  endtask
  task op(input [6:0] c, input [7:0] a);
    begin
      wr(`ECS_OFF_CMD, {25'h0, c});
      wr(`ECS_OFF_ADDR, {24'h0, a});
      wr(`ECS_OFF_CONTROL_REGISTER_A, 32'h1);
    end
  endtask
  task idle;
    begin
      i = 0;
      r = 32'h1;
      while (r[0] !== 1'b0 && i < 100) begin
        i_host.xfer(1'b0, `ECS_OFF_STATUS, 32'h0, r, e);
        i = i + 1;
      end
      cmp(r & 32'h1, 32'h0);
    end
  endtask
  task ld(input [7:0] a, input [7:0] d);
    begin
      wr(`ECS_OFF_CMD, {25'h0, `ECS_OP_LOAD_BUF});
      wr(`ECS_OFF_ADDR, {24'h0, a});
      wr(`ECS_OFF_DATA, {24'h0, d});
    end
  endtask
  task peek(input [7:0] a, input [7:0] x);
    begin
      op(`ECS_OP_READ, a);
      rd(`ECS_OFF_DATA, {24'h0, x});
    end
  endtask
  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
        $display("Result: passed");
      end else begin
        $display("Result: failed");
      end
      $finish;
    end
  endtask
  initial begin
    #20000;
    bad_count = bad_count + 1;
    tally_and_finish;
  end
  initial begin
    presetn = 1'b0;
    bad_count = 0;
    check_count = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd(`ECS_OFF_STATUS, 32'h0);
    rd(12'h018, 32'h0);
    cmp({31'h0, e}, 32'h1);
    peek(8'h23, 8'hFF);
    $display("test reset done");
    ld(8'h43, 8'h5A);
    ld(8'h44, 8'hC3);
    op(`ECS_OP_WRITE_PAGE, 8'h20);
    rd(`ECS_OFF_STATUS, 32'h3);
    idle;
    peek(8'h23, 8'h5A);
    peek(8'h25, 8'hFF);
    $display("test page write done");
    op(`ECS_OP_ERASE_BUF, 8'h00);
    rd(`ECS_OFF_STATUS, 32'h1);
    idle;
    ld(8'h43, 8'h00);
    op(`ECS_OP_ERASE_PAGE, 8'h20);
    idle;
    peek(8'h23, 8'hFF);
    peek(8'h24, 8'hC3);
    ld(8'h43, 8'h00);
    op(`ECS_OP_ERASE_WRITE, 8'h40);
    idle;
    peek(8'h43, 8'h00);
    peek(8'h44, 8'hFF);
    ld(8'h43, 8'h00);
    op(`ECS_OP_ERASE_ALL, 8'h00);
    idle;
    peek(8'h43, 8'hFF);
    peek(8'h24, 8'hC3);
    $display("test page ops done");
    wr(`ECS_OFF_DBG, 32'h59);
    wr(`ECS_OFF_DBG, 32'hA5);
    rd(`ECS_OFF_STATUS, 32'h4);
    wr(`ECS_OFF_DBG, 32'h59);
    rd(`ECS_OFF_STATUS, 32'h0);
    $display("test debug enable done");
    tally_and_finish;
  end
endmodule
